// >>> hdl/wdg_top.sv
// watchdog timer with postscaler, window mode and apb registers
`timescale 1ns/1ps

// Contract
// - count runs on low-power oscillator ticks
// - unserviced expiry requests device reset
// - postscaler selects the time-out period
// - expiry in sleep or idle wakes device
// - writing enable one starts software watchdog
// - enable zero stops only software-enabled watchdog
// - enable bit reads one while running
// - shadow postscale read-only, loaded from configuration
// - window bit selects windowed or normal mode
// - clear bit one restarts count, zero ignored
// - unimplemented bits read zero, ignore writes
// - clear, set, invert aliases modify written ones
// - reset contents follow configuration and reset
module wdg_top #(
    parameter int unsigned DIV = wdg_pkg::OSC_DIV
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      cfg_enable,
    input  wire logic [wdg_pkg::PS_W-1:0]  cfg_postscale_sel,
    input  wire logic                      sleep_mode,
    input  wire logic                      idle_mode,
    output logic                           device_reset_req,
    output logic                           wake_req,
    output logic                           irq
);
    import wdg_pkg::*;

    wdg_state_t       state_reg;
    wdg_ctrl_t        ctrl;
    wdg_evt_t         stat_reg;
    wdg_evt_t         mask_reg;
    wdg_evt_t         evt;
    logic             cap_done_reg;
    logic             cfg_en_reg;
    logic [PS_W-1:0]  ps_reg;
    logic             sw_on_reg;
    logic             win_reg;
    logic [31:0]      div_reg;
    logic             tick;
    logic [PS_MAX-1:0] cnt_reg;
    logic [PS_MAX:0]  period;
    logic [PS_MAX:0]  half;
    logic [4:0]       sel_eff;
    logic             running;
    logic             low_power;
    logic             expire;
    logic             early;
    logic             access;
    logic             wr_ctrl;
    logic             rd_stat;
    logic [31:0]      ctrl_old;
    logic [31:0]      ctrl_new;
    logic             clr_req;
    logic             hit;
    logic [31:0]      rd_mux;
    logic             pready_reg;
    logic [31:0]      prdata_reg;
    logic             pslverr_reg;
    logic             rst_req_reg;
    logic             wake_reg;
    logic             irq_reg;

    // outputs straight from flops
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign device_reset_req = rst_req_reg;
    assign wake_req         = wake_reg;
    assign irq              = irq_reg;

    // clear, set and invert alias arithmetic
    function automatic logic [31:0] alias_op(
        input logic [7:0]  a,
        input logic [31:0] o,
        input logic [31:0] d
    );
        case (a)
            CLR_OFS: alias_op = o & ~d;
            SET_OFS: alias_op = o | d;
            INV_OFS: alias_op = o ^ d;
            default: alias_op = d;
        endcase
    endfunction

    // bus decode, completing edge is the second access cycle
    assign access  = psel & penable & pready_reg;
    assign hit     = (paddr == CTRL_OFS) | (paddr == CLR_OFS)
                   | (paddr == SET_OFS) | (paddr == INV_OFS)
                   | (paddr == STAT_OFS) | (paddr == MASK_OFS);
    // unmapped words in the control group must not touch the control bits
    assign wr_ctrl = access & pwrite & hit & (paddr[7:4] == 4'h0);
    assign rd_stat = access & ~pwrite & (paddr == STAT_OFS);

    // software view; bit 0 always reads zero
    assign ctrl.on  = running;
    assign ctrl.ps  = ps_reg;
    assign ctrl.win = win_reg;
    assign ctrl_old = {16'h0000, sw_on_reg, 8'h00, ps_reg, win_reg, 1'b0};
    assign ctrl_new = alias_op(paddr, ctrl_old, pwdata);
    assign clr_req  = wr_ctrl & ctrl_new[CLR_BIT];

    // read data, unimplemented bits zero
    always_comb begin
        rd_mux = RD_RST;
        case (paddr)
            CTRL_OFS, CLR_OFS, SET_OFS, INV_OFS: begin
                rd_mux[ON_BIT] = ctrl.on;
                rd_mux[PS_LSB +: PS_W] = ctrl.ps;
                rd_mux[WIN_BIT] = ctrl.win;
            end
            STAT_OFS: rd_mux[2:0] = stat_reg;
            MASK_OFS: rd_mux[2:0] = mask_reg;
            default: rd_mux = RD_RST;
        endcase
    end

    // apb answer: one wait state, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= RD_RST;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel & penable & ~pready_reg;
            prdata_reg  <= rd_mux;
            pslverr_reg <= psel & penable & ~pready_reg & ~hit;
        end
    end

    // configuration captured once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_done_reg <= 1'b0;
            cfg_en_reg   <= 1'b0;
            ps_reg       <= '0;
        end else if (!cap_done_reg) begin
            cap_done_reg <= 1'b1;
            cfg_en_reg   <= cfg_enable;
            ps_reg       <= cfg_postscale_sel;
        end
    end

    // software enable and window bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_on_reg <= ON_RST;
            win_reg   <= WIN_RST;
        end else if (wr_ctrl) begin
            sw_on_reg <= ctrl_new[ON_BIT];
            win_reg   <= ctrl_new[WIN_BIT];
        end
    end

    // configuration enable cannot be undone by software
    assign running   = cfg_en_reg | sw_on_reg;
    assign low_power = sleep_mode | idle_mode;

    // low-power oscillator tick as enable pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else if (!running || div_reg == DIV - 1) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 32'd1;
        end
    end
    assign tick = running && (div_reg == DIV - 1);

    // postscaled period and window threshold
    assign sel_eff = (ps_reg > PS_W'(PS_MAX)) ? 5'(PS_MAX) : ps_reg;
    assign period  = (PS_MAX+1)'(1) << sel_eff;
    assign half    = period >> 1;
    // a clear landing on the last tick counts as service
    assign expire  = tick && !clr_req
                   && ({1'b0, cnt_reg} == period - 1'b1);
    assign early   = win_reg && ({1'b0, cnt_reg} < half);

    // postscaler count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (!running || clr_req || expire) begin
            cnt_reg <= '0;
        end else if (tick && state_reg == WDG_RUN) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // events of this cycle
    assign evt.wake    = expire && low_power && state_reg == WDG_RUN;
    assign evt.rst     = expire && !low_power && state_reg == WDG_RUN;
    assign evt.win_err = clr_req && early && state_reg == WDG_RUN;

    // run state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WDG_OFF;
        end else begin
            case (state_reg)
                WDG_OFF: begin
                    if (running) state_reg <= WDG_RUN;
                end
                WDG_RUN: begin
                    if (evt.rst || evt.win_err) begin
                        state_reg <= WDG_FIRED;
                    end else if (!running) begin
                        state_reg <= WDG_OFF;
                    end
                end
                WDG_FIRED: state_reg <= WDG_FIRED;
                default:   state_reg <= WDG_OFF;
            endcase
        end
    end

    // reset request held until device reset, wake is a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_req_reg <= 1'b0;
            wake_reg    <= 1'b0;
        end else begin
            if (evt.rst || evt.win_err) rst_req_reg <= 1'b1;
            wake_reg <= evt.wake;
        end
    end

    // sticky status, set wins over read clear; mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= STAT_RST;
            mask_reg <= MASK_RST;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= (rd_stat ? STAT_RST : stat_reg) | evt;
            if (access && pwrite && paddr == MASK_OFS) begin
                mask_reg <= pwdata[2:0];
            end
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // one completed apb write to an address
    sequence seq_wr(logic [7:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    // single-cycle pulse
    sequence seq_pulse(logic s);
        s ##1 !s;
    endsequence

    a_apb_one_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("apb answer not after one wait");

    a_unimpl_zero: assert property (
        pready && !pwrite && paddr[7:4] == 4'h0 |->
        prdata[31:16] == 16'h0000 && prdata[14:7] == 8'h00
        && prdata[0] == 1'b0)
        else $error("unimplemented control bits not zero");

    a_on_reads_run: assert property (
        pready && !pwrite && paddr == CTRL_OFS |->
        prdata[ON_BIT] == $past(running))
        else $error("enable bit does not show running");

    a_sw_start: assert property (
        seq_wr(SET_OFS) ##0 pwdata[ON_BIT] |=> running)
        else $error("set alias did not start watchdog");

    a_cfg_keeps_on: assert property (
        seq_wr(CLR_OFS) ##0 cfg_en_reg |=> running [*2])
        else $error("configured watchdog was stopped");

    a_clear_count: assert property (
        clr_req && state_reg == WDG_RUN && !early
        |=> cnt_reg == '0 && !device_reset_req)
        else $error("clear did not restart count");

    a_expiry_reset: assert property (
        evt.rst |=> device_reset_req [*3])
        else $error("expiry did not hold reset request");

    a_expiry_wake: assert property (
        evt.wake |=> seq_pulse(wake_req) ##0 !device_reset_req)
        else $error("sleep expiry did not wake once");

    a_shadow_fixed: assert property (
        cap_done_reg && !$rose(cap_done_reg) |-> $stable(ps_reg))
        else $error("shadow postscale changed");

    a_disable_zero: assert property (
        $fell(running) |=> cnt_reg == '0)
        else $error("count not zeroed on disable");

endmodule // wdg_top

// >>> shared/wdg_pkg.sv
// package: watchdog register map, field layout, counts and types
package wdg_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CLR_OFS  = 8'h04;
    localparam logic [7:0] SET_OFS  = 8'h08;
    localparam logic [7:0] INV_OFS  = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    // control field positions
    localparam int unsigned ON_BIT  = 15;
    localparam int unsigned PS_LSB  = 2;
    localparam int unsigned PS_W    = 5;
    localparam int unsigned WIN_BIT = 1;
    localparam int unsigned CLR_BIT = 0;
    // reset values
    localparam logic        ON_RST   = 1'b0;
    localparam logic        WIN_RST  = 1'b0;
    localparam logic [2:0]  STAT_RST = 3'h0;
    localparam logic [2:0]  MASK_RST = 3'h0;
    localparam logic [31:0] RD_RST   = 32'h0000_0000;
    // longest postscale exponent, period is 2**sel oscillator ticks
    localparam int unsigned PS_MAX = 20;
    // clock rates and the oscillator tick divider
    localparam int unsigned CLK_HZ   = 125_000_000;
    localparam int unsigned LPOSC_HZ = 32_000;
    localparam int unsigned OSC_DIV  = CLK_HZ / LPOSC_HZ;
    // watchdog states
    typedef enum logic [1:0] {
        WDG_OFF   = 2'b00,
        WDG_RUN   = 2'b01,
        WDG_FIRED = 2'b10
    } wdg_state_t;
    // software view of the control register
    typedef struct packed {
        logic            on;
        logic [PS_W-1:0] ps;
        logic            win;
    } wdg_ctrl_t;
    // sticky events: window error, reset expiry, wake expiry
    typedef struct packed {
        logic win_err;
        logic rst;
        logic wake;
    } wdg_evt_t;
endpackage

// >>> bench/wdg_top_tb.sv
// testbench: watchdog register and expiry scenarios over apb
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module wdg_top_tb;
    import wdg_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cfg_enable;
    logic [4:0]  cfg_postscale_sel;
    logic        sleep_mode;
    logic        idle_mode;
    logic        device_reset_req;
    logic        wake_req;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          failures;
    int          compares;
    int          cycles;
    int          waited;

    wdg_top #(.DIV(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_enable(cfg_enable),
        .cfg_postscale_sel(cfg_postscale_sel), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode), .device_reset_req(device_reset_req),
        .wake_req(wake_req), .irq(irq)
    );

    // 125 MHz clock
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // reset with straps held stable around release
    task do_reset(input logic en, input logic [4:0] sel);
        presetn    <= 1'b0;
        cfg_enable <= en;
        cfg_postscale_sel <= sel;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // one apb transfer, result sampled at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        `CHK("pready", 1'b1, pready);
        `CHK("wait", 2, n);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("rdata", e, rdat);
    endtask

    // bounded wait for an output to go high
    task wait_out(input bit wk);
        int n;
        n = 0;
        while ((wk ? wake_req : device_reset_req) !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        waited = n;
        `CHK("event", 1'b1, wk ? wake_req : device_reset_req);
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cfg_enable = 1'b0;
        cfg_postscale_sel = 5'h03;
        sleep_mode = 1'b0;
        idle_mode = 1'b0;
        failures = 0;
        compares = 0;
        cycles = 0;
        do_reset(1'b0, 5'h03);
        rd(CTRL_OFS, 32'h0000_000C);
        apb(1'b1, CTRL_OFS, 32'hFFFF_7FFC);
        rd(CTRL_OFS, 32'h0000_000C);
        apb(1'b1, INV_OFS, 32'h0000_0002);
        rd(CTRL_OFS, 32'h0000_000E);
        apb(1'b1, CLR_OFS, 32'h0000_0002);
        apb(1'b1, SET_OFS, 32'h0000_8000);
        rd(CTRL_OFS, 32'h0000_800C);
        apb(1'b1, CLR_OFS, 32'h0000_8000);
        rd(CTRL_OFS, 32'h0000_000C);
        rd(8'h40, 32'h0000_0000);
        `CHK("pslverr", 1'b1, rerr);
        apb(1'b1, MASK_OFS, 32'h0000_0007);
        rd(MASK_OFS, 32'h0000_0007);
        $display("test registers done");
        // serviced watchdog never fires, 32-cycle period
        apb(1'b1, CTRL_OFS, 32'h0000_8000);
        repeat (20) apb(1'b1, CTRL_OFS, 32'h0000_8001);
        `CHK("no_reset", 1'b0, device_reset_req);
        // clear written zero leaves the count running
        repeat (12) apb(1'b1, CTRL_OFS, 32'h0000_8000);
        wait_out(1'b0);
        rd(STAT_OFS, 32'h0000_0002);
        `CHK("irq_set", 1'b1, irq);
        rd(STAT_OFS, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        `CHK("irq_clr", 1'b0, irq);
        `CHK("rst_hold", 1'b1, device_reset_req);
        $display("test expiry done");
        // early clear in window mode
        do_reset(1'b0, 5'h03);
        apb(1'b1, CTRL_OFS, 32'h0000_8002);
        apb(1'b1, CTRL_OFS, 32'h0000_8003);
        wait_out(1'b0);
        `CHK("irq_mask", 1'b0, irq);
        rd(STAT_OFS, 32'h0000_0004);
        $display("test window done");
        // expiry in sleep and then idle wakes
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b0, 5'h02);
            sleep_mode <= (m == 0);
            idle_mode  <= (m == 1);
            apb(1'b1, SET_OFS, 32'h0000_8000);
            wait_out(1'b1);
            `CHK("period", 4 * (1 << 2) + 1, waited);
            `CHK("no_rst", 1'b0, device_reset_req);
            rd(STAT_OFS, 32'h0000_0001);
            sleep_mode <= 1'b0;
            idle_mode  <= 1'b0;
        end
        $display("test wake done");
        // watchdog enabled by configuration
        do_reset(1'b1, 5'h05);
        rd(CTRL_OFS, 32'h0000_8014);
        apb(1'b1, CLR_OFS, 32'h0000_8000);
        rd(CTRL_OFS, 32'h0000_8014);
        $display("test config done");
        print_verdict();
    end
endmodule // wdg_top_tb
